//--- hdl/sfsp_regfile.sv
// Purpose: Control storage, fault registers and information bytes
// Assumes: Fault inputs are one-cycle events on sys_clk
// Notes: Events seen while frozen are held and applied afterwards
`timescale 1ns/1ps
`default_nettype none
module sfsp_regfile #(
  parameter int CH = 4,
  parameter logic [7:0] INFO_ID = 8'h5a,   // Arbitrary value
  parameter logic [7:0] INFO_VER = 8'h01,  // Arbitrary value
  parameter logic [7:0] INFO_PROD1 = 8'h11, // Arbitrary value
  parameter logic [7:0] INFO_PROD2 = 8'h22  // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Engine side
  sfsp_reg_if.regs bus,
  // Channel fault events, in address order
  input wire logic [CH-1:0] fault_ev [sfsp_pkg::NUM_STAT],
  // Read-only status sources
  input wire logic [7:0] channel_readback,
  input wire logic [7:0] general_status,
  // Stored settings
  output logic [7:0] control_reg,
  output logic [7:0] configuration_reg
);
  import sfsp_pkg::*;
  logic [7:0] ram_q [64];
  logic [7:0] ram_d [64];
  logic [CH-1:0] stat_q [NUM_STAT];
  logic [CH-1:0] stat_d [NUM_STAT];
  logic [CH-1:0] pend_q [NUM_STAT];
  logic [CH-1:0] pend_d [NUM_STAT];

  // Next state: writes, clears, event merge
  always_comb begin
    logic clr;
    clr = 1'b0;
    for (int i = 0; i < 64; i++) begin
      ram_d[i] = ram_q[i];
    end
    if (bus.commit && bus.op == OP_WRITE && sfsp_ram_hit(bus.addr)) begin
      ram_d[bus.addr] = bus.wdata; // RULE_16
    end
    for (int i = 0; i < NUM_STAT; i++) begin
      clr = bus.commit && bus.op == OP_RDCLR &&
        (bus.addr == A_THERM + 6'(i) || bus.addr == A_CONFIG); // RULE_21
      if (bus.frozen) begin
        stat_d[i] = stat_q[i]; // RULE_19
        pend_d[i] = pend_q[i] | fault_ev[i];
      end else begin
        // A new event beats a clear in the same cycle
        stat_d[i] = (clr ? '0 : stat_q[i]) | pend_q[i] | fault_ev[i]; // RULE_20
        pend_d[i] = '0;
      end
    end
  end

  // Register group
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 64; i++) begin
        ram_q[i] <= REG_RESET;
      end
      for (int i = 0; i < NUM_STAT; i++) begin
        stat_q[i] <= '0;
        pend_q[i] <= '0;
      end
    end else begin
      ram_q <= ram_d;
      stat_q <= stat_d;
      pend_q <= pend_d;
    end
  end

  // Read mux; unassigned addresses read as zero
  always_comb begin
    bus.rdata = 8'h00; // RULE_18
    if (bus.op == OP_INFO) begin
      unique case (bus.addr)
        A_INFO_ID: bus.rdata = INFO_ID; // RULE_22
        A_INFO_VER: bus.rdata = INFO_VER;
        A_INFO_PROD1: bus.rdata = INFO_PROD1;
        A_INFO_PROD2: bus.rdata = INFO_PROD2;
        A_INFO_FRAME: bus.rdata = FRAME_WIDTH_INFO;
        default: bus.rdata = 8'h00;
      endcase
    end else if (sfsp_ram_hit(bus.addr)) begin
      bus.rdata = ram_q[bus.addr];
    end else if (sfsp_stat_hit(bus.addr)) begin
      bus.rdata = 8'(stat_q[3'(bus.addr - A_THERM)]);
    end else if (bus.addr == A_READBACK) begin
      bus.rdata = channel_readback;
    end else if (bus.addr == A_GENERAL) begin
      bus.rdata = general_status;
    end
  end

  // Fault summaries for the status byte
  assign bus.summary[2] = |stat_q[0] | |stat_q[3] | |stat_q[4]; // RULE_10
  assign bus.summary[1] = |stat_q[1]; // RULE_12
  assign bus.summary[0] = |stat_q[2]; // RULE_13
  assign control_reg = ram_q[A_CTRL];
  assign configuration_reg = ram_q[A_CONFIG];
endmodule : sfsp_regfile
`default_nettype wire

//--- hdl/sfsp_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are slow against sys_clk
// Notes: Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module sfsp_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Both stages in one register group
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sfsp_sync
`default_nettype wire

//--- hdl/sfsp_top.sv
// Purpose: Serial frame engine with global status byte
// Assumes: Link pins are asynchronous and sampled on sys_clk
// Notes: Link clock must stay well below sys_clk (125 ns in bench)
// Contract
// (RULE_01) First byte: two-bit opcode over six-bit address, then data.
// (RULE_02) Opcodes: 00 write, 01 read, 10 read-clear, 11 info.
// (RULE_03) Output frame is status byte then data byte, MSB first.
// (RULE_04) Bit 7 global error flag, resets 1, ORs all error sources.
// (RULE_05) Error flag shown with select low and clock idle, no error.
// (RULE_06) Bit 6 set at frame end on bad pulse count or mode.
// (RULE_07) Pulse count must match frame width info, else frame ignored.
// (RULE_08) Communication error seen next frame, cleared by valid frame.
// (RULE_09) Bit 5 low after chip reset or error; high after valid frame.
// (RULE_10) Bit 4 ORs thermal, power limit and overload registers.
// (RULE_11) Bit 3 follows the case overtemperature prewarning level.
// (RULE_12) Bit 2 ORs the on-state open-load register.
// (RULE_13) Bit 1 ORs the off-state open-load or stuck register.
// (RULE_14) Bit 0 high in failsafe mode, resets to 1.
// (RULE_15) Master treats status FFh or 00h as link failure.
// (RULE_16) Write stores data, returns old content in the same frame.
// (RULE_17) First bit at select fall, then on clock falls; sample rises.
// (RULE_18) Read returns register content; unassigned gives 00h.
// (RULE_19) Status registers are frozen while a frame runs.
// (RULE_20) Read-clear returns then clears the addressed status register.
// (RULE_21) Read-clear at 3Fh clears all, returns configuration register.
// (RULE_22) Info read returns info byte, data ignored, never modified.
// (RULE_23) Only exactly sixteen bits accepted; output off while deselected.
// (RULE_24) Master uses clock polarity 0, phase 0, clock low at start.
// (RULE_25) Unassigned address: no effect on storage or status flags.
// (RULE_26) Commit only at select rise after a valid pulse count.
`timescale 1ns/1ps
`default_nettype none
module sfsp_top #(
  parameter int CH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Serial link pins
  input wire logic spi_sck,
  input wire logic spi_csn_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Channel fault events
  input wire logic [CH-1:0] thermal_shutdown_fault,
  input wire logic [CH-1:0] open_load_on_fault,
  input wire logic [CH-1:0] open_load_off_fault,
  input wire logic [CH-1:0] power_limit_fault,
  input wire logic [CH-1:0] overload_fault,
  // Device conditions
  input wire logic case_overtemp,
  input wire logic select_monitor_timeout,
  input wire logic supply_undervoltage,
  input wire logic pwm_clock_low,
  input wire logic failsafe_mode,
  input wire logic soft_reset,
  // Read-only status sources
  input wire logic [7:0] channel_readback,
  input wire logic [7:0] general_status,
  // Stored settings
  output logic [7:0] control_reg,
  output logic [7:0] configuration_reg
);
  import sfsp_pkg::*;

  // Frame states, Gray along the usual path except S_DONE to S_IDLE
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CMD = 3'h1,
    S_LOAD = 3'h3,
    S_DATA = 3'h2,
    S_DONE = 3'h6
  } sfsp_state_e;

  sfsp_reg_if rif ();
  logic [CH-1:0] fault_ev [NUM_STAT];
  logic sck_s;
  logic csn_s;
  logic sdi_s;
  logic sck_p_q;
  logic csn_p_q;
  logic sck_rise;
  logic sck_fall;
  logic csn_fall;
  logic csn_rise;

  // Pins cross into sys_clk; select idles high
  sfsp_sync #(
    .W(3),
    .INIT(3'h2)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d({spi_sck, spi_csn_n, spi_sdi}),
    .q({sck_s, csn_s, sdi_s})
  );

  // Previous synchronised levels for edge finding
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sck_p_q <= 1'b0;
      csn_p_q <= 1'b1;
    end else begin
      sck_p_q <= sck_s;
      csn_p_q <= csn_s;
    end
  end

  // Edges only while selected; select edges are global
  assign csn_fall = csn_p_q && !csn_s;
  assign csn_rise = !csn_p_q && csn_s;
  assign sck_rise = !csn_s && !csn_p_q && sck_s && !sck_p_q;
  assign sck_fall = !csn_s && !csn_p_q && !sck_s && sck_p_q;

  // Fault events in status register address order
  assign fault_ev[0] = thermal_shutdown_fault;
  assign fault_ev[1] = open_load_on_fault;
  assign fault_ev[2] = open_load_off_fault;
  assign fault_ev[3] = power_limit_fault;
  assign fault_ev[4] = overload_fault;

  sfsp_regfile #(
    .CH(CH)
  ) u_regs (
    .sys_clk(sys_clk),
    .reset(reset),
    .bus(rif.regs),
    .fault_ev(fault_ev),
    .channel_readback(channel_readback),
    .general_status(general_status),
    .control_reg(control_reg),
    .configuration_reg(configuration_reg)
  );

  // Frame engine state
  sfsp_state_e st_q;
  sfsp_state_e st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [15:0] in_q;
  logic [15:0] in_d;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic sdo_d;
  logic oe_d;
  logic mode_bad_q;
  logic mode_bad_d;
  logic fin_ok_q;
  logic fin_ok_d;
  logic fin_bad_q;
  logic fin_bad_d;

  // Status flag state
  logic comerr_q;
  logic comerr_d;
  logic chiprst_q;
  logic chiprst_d;
  logic failsafe_q;
  logic failsafe_d;
  logic [7:0] gbyte;
  logic hit;

  // Global status byte, built from the flags and summaries
  always_comb begin
    gbyte = 8'h00;
    gbyte[SB_GLOBAL] = chiprst_q | comerr_q | |rif.summary |
      select_monitor_timeout | supply_undervoltage | pwm_clock_low; // RULE_04
    gbyte[SB_COMERR] = comerr_q; // RULE_06
    gbyte[SB_NRESET] = !(chiprst_q || comerr_q); // RULE_09
    gbyte[SB_POWER] = rif.summary[2]; // RULE_10
    gbyte[SB_CASE] = case_overtemp; // RULE_11
    gbyte[SB_OPEN_ON] = rif.summary[1]; // RULE_12
    gbyte[SB_OPEN_OFF] = rif.summary[0]; // RULE_13
    gbyte[SB_FAILSAFE] = failsafe_q; // RULE_14
  end

  // Register port: command fields drive address and operation
  assign rif.addr = cmd_q[5:0]; // RULE_01
  assign rif.op = sfsp_op_e'(cmd_q[7:6]); // RULE_02
  assign rif.wdata = in_q[7:0];
  assign rif.frozen = st_q == S_CMD || st_q == S_LOAD ||
    st_q == S_DATA; // RULE_19
  assign hit = sfsp_assigned(rif.op, rif.addr); // RULE_25
  assign rif.commit = st_q == S_DONE && fin_ok_q && hit; // RULE_26

  // Frame engine next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    in_d = in_q;
    cmd_d = cmd_q;
    out_d = out_q;
    sdo_d = spi_sdo;
    oe_d = spi_sdo_oe;
    mode_bad_d = mode_bad_q;
    fin_ok_d = fin_ok_q;
    fin_bad_d = fin_bad_q;
    // Input bits on clock rises, counted with saturation
    if (sck_rise) begin
      in_d = {in_q[14:0], sdi_s}; // RULE_17
      if (cnt_q != 5'h1f) begin
        cnt_d = cnt_q + 5'h01; // RULE_07
      end
    end
    // Output bits advance on clock falls
    if (sck_fall) begin
      sdo_d = out_q[7]; // RULE_17
      out_d = {out_q[6:0], 1'b0};
    end
    unique case (st_q)
      S_IDLE: begin
        if (csn_fall) begin
          st_d = S_CMD;
          cnt_d = 5'h00;
          sdo_d = gbyte[7]; // RULE_05
          out_d = {gbyte[6:0], 1'b0}; // RULE_03
          oe_d = 1'b1;
          // Clock high at select fall means wrong mode
          mode_bad_d = sck_s; // RULE_24
        end
      end
      S_CMD: begin
        if (cnt_q == CMD_BITS) begin
          st_d = S_LOAD;
          cmd_d = in_q[7:0]; // RULE_01
        end
      end
      S_LOAD: begin
        // Data byte loaded before the eighth falling edge
        out_d = rif.rdata; // RULE_18
        st_d = S_DATA;
      end
      S_DATA: begin
      end
      S_DONE: begin
        st_d = S_IDLE;
      end
    endcase
    // Select rise ends any frame in progress
    if (csn_rise && rif.frozen) begin
      st_d = S_DONE;
      oe_d = 1'b0; // RULE_23
      sdo_d = 1'b0;
      fin_ok_d = cnt_q == FRAME_BITS && !mode_bad_q && !sck_s; // RULE_23
      // An idle sample with no pulses is not an error
      fin_bad_d = !fin_ok_d && cnt_q != 5'h00; // RULE_05
    end
  end

  // Frame engine registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= S_IDLE;
      cnt_q <= 5'h00;
      in_q <= 16'h0000;
      cmd_q <= 8'h00;
      out_q <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
      mode_bad_q <= 1'b0;
      fin_ok_q <= 1'b0;
      fin_bad_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      in_q <= in_d;
      cmd_q <= cmd_d;
      out_q <= out_d;
      spi_sdo <= sdo_d;
      spi_sdo_oe <= oe_d;
      mode_bad_q <= mode_bad_d;
      fin_ok_q <= fin_ok_d;
      fin_bad_q <= fin_bad_d;
    end
  end

  // Status flags; a soft reset wins over a clearing frame
  always_comb begin
    comerr_d = comerr_q;
    chiprst_d = chiprst_q;
    failsafe_d = failsafe_mode; // RULE_14
    if (st_q == S_DONE && fin_bad_q) begin
      comerr_d = 1'b1; // RULE_06
    end else if (st_q == S_DONE && fin_ok_q && hit) begin
      // Unassigned addresses leave every flag alone
      comerr_d = 1'b0; // RULE_08
      chiprst_d = 1'b0; // RULE_09
    end
    if (soft_reset) begin
      chiprst_d = 1'b1; // RULE_09
    end
  end

  // Status flag registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      comerr_q <= COMERR_RESET;
      chiprst_q <= CHIPRST_RESET; // RULE_04
      failsafe_q <= FAILSAFE_RESET;
    end else begin
      comerr_q <= comerr_d;
      chiprst_q <= chiprst_d;
      failsafe_q <= failsafe_d;
    end
  end
endmodule : sfsp_top
`default_nettype wire

//--- shared/sfsp_pkg.sv
// Purpose: Shared constants and decode helpers for the frame engine
// Assumes: 6-bit address space, 8-bit registers, 16-bit frames
// Notes: Status register order follows their addresses
`default_nettype none
package sfsp_pkg;
  // Operation codes carried in the two top command bits
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_RDCLR = 2'h2,
    OP_INFO = 2'h3
  } sfsp_op_e;

  // Frame shape
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [7:0] FRAME_WIDTH_INFO = 8'h01;

  // Register addresses
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_CTRL_LAST = 6'h09;
  localparam logic [5:0] A_DUTY_FIRST = 6'h10;
  localparam logic [5:0] A_DUTY_LAST = 6'h13;
  localparam logic [5:0] A_PHASE_FIRST = 6'h18;
  localparam logic [5:0] A_PHASE_LAST = 6'h1b;
  localparam logic [5:0] A_READBACK = 6'h2e;
  localparam logic [5:0] A_GENERAL = 6'h2f;
  localparam logic [5:0] A_THERM = 6'h30;
  localparam logic [5:0] A_OPEN_ON = 6'h31;
  localparam logic [5:0] A_OPEN_OFF = 6'h32;
  localparam logic [5:0] A_PLIM = 6'h33;
  localparam logic [5:0] A_OVLD = 6'h34;
  localparam logic [5:0] A_TEST_REG = 6'h3e;
  localparam logic [5:0] A_CONFIG = 6'h3f;
  localparam int NUM_STAT = 5;

  // Information space addresses
  localparam logic [5:0] A_INFO_ID = 6'h00;
  localparam logic [5:0] A_INFO_VER = 6'h01;
  localparam logic [5:0] A_INFO_PROD1 = 6'h02;
  localparam logic [5:0] A_INFO_PROD2 = 6'h03;
  localparam logic [5:0] A_INFO_FRAME = 6'h3e;

  // Global status byte bit positions
  localparam int SB_GLOBAL = 7;
  localparam int SB_COMERR = 6;
  localparam int SB_NRESET = 5;
  localparam int SB_POWER = 4;
  localparam int SB_CASE = 3;
  localparam int SB_OPEN_ON = 2;
  localparam int SB_OPEN_OFF = 1;
  localparam int SB_FAILSAFE = 0;

  // Reset values
  localparam logic COMERR_RESET = 1'b0;
  localparam logic CHIPRST_RESET = 1'b1;
  localparam logic FAILSAFE_RESET = 1'b1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Writable storage locations
  function automatic logic sfsp_ram_hit(input logic [5:0] a);
    return (a <= A_CTRL_LAST) ||
      (a >= A_DUTY_FIRST && a <= A_DUTY_LAST) ||
      (a >= A_PHASE_FIRST && a <= A_PHASE_LAST) ||
      a == A_TEST_REG || a == A_CONFIG;
  endfunction : sfsp_ram_hit

  // Read-and-clear fault registers
  function automatic logic sfsp_stat_hit(input logic [5:0] a);
    return a >= A_THERM && a <= A_OVLD;
  endfunction : sfsp_stat_hit

  // Address holds something for this operation
  function automatic logic sfsp_assigned(input sfsp_op_e op,
                                         input logic [5:0] a);
    if (op == OP_INFO) begin
      return a <= A_INFO_PROD2 || a == A_INFO_FRAME;
    end
    return sfsp_ram_hit(a) || sfsp_stat_hit(a) ||
      a == A_READBACK || a == A_GENERAL;
  endfunction : sfsp_assigned
endpackage : sfsp_pkg
`default_nettype wire

//--- shared/sfsp_reg_if.sv
// Purpose: Link between frame engine and register file
// Assumes: Both ends on sys_clk
// Notes: rdata and summary are combinational from the register file
`timescale 1ns/1ps
`default_nettype none
interface sfsp_reg_if;
  import sfsp_pkg::*;
  logic [5:0] addr;
  sfsp_op_e op;
  logic [7:0] wdata;
  logic commit;
  logic frozen;
  logic [7:0] rdata;
  logic [2:0] summary;
  modport engine(output addr, op, wdata, commit, frozen,
                 input rdata, summary);
  modport regs(input addr, op, wdata, commit, frozen,
               output rdata, summary);
endinterface : sfsp_reg_if
`default_nettype wire

//--- sim/sfsp_master_model.sv
// Purpose: Serial master model, clock polarity 0 and phase 0
// Assumes: 125 ns link clock, free of the system clock phase
// Notes: Pulse counts other than 16 break framing on purpose
`timescale 1ns/1ps
`default_nettype none
module sfsp_master_model (
  // Link pins
  output logic spi_sck,
  output logic spi_csn_n,
  output logic spi_sdi,
  input wire logic spi_sdo,
  // Received word
  output logic [15:0] rx_word,
  output logic rx_stb
);
  localparam realtime HALF = 62.5;
  // Idle: deselected, clock low
  initial begin
    spi_sck = 1'b0;
    spi_csn_n = 1'b1;
    spi_sdi = 1'b0;
    rx_word = 16'h0000;
    rx_stb = 1'b0;
  end
  // One frame; zero pulses only samples the flag bit
  task automatic xfer(input logic [15:0] tx, input int pulses);
    logic [15:0] sh;
    logic first;
    int n;
    // Counts above 99 start the frame with the clock high
    n = (pulses > 99) ? pulses - 100 : pulses;
    sh = 16'h0000;
    spi_sck = pulses > 99;
    spi_sdi = tx[15];
    spi_csn_n = 1'b0;
    #HALF;
    first = spi_sdo;
    for (int i = 0; i < n; i++) begin
      spi_sck = 1'b1;
      sh = {sh[14:0], spi_sdo};
      #HALF;
      spi_sck = 1'b0;
      spi_sdi = (i < 15) ? tx[14-i] : ~spi_sdi;
      #HALF;
    end
    spi_csn_n = 1'b1;
    spi_sdi = ~spi_sdi;
    rx_word = (pulses == 0) ? {first, 15'h0000} : sh;
    rx_stb = 1'b1;
    #1;
    rx_stb = 1'b0;
    #250;
  endtask : xfer
endmodule : sfsp_master_model
`default_nettype wire

//--- sim/sfsp_top_sva.sv
// Purpose: Port-level checks for the serial frame engine
// Assumes: Link pins slow against sys_clk, 2-FF sync plus edge detect
// Notes: Latency windows follow the engine's sync depth
`timescale 1ns/1ps
`default_nettype none
module sfsp_top_chk #(
  parameter int CH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Link pins
  input wire logic spi_sck,
  input wire logic spi_csn_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  // Conditions and settings
  input wire logic supply_undervoltage,
  input wire logic [7:0] control_reg,
  input wire logic [7:0] configuration_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Reset itself is the cause here, so it cannot disable the check
  reset_quiet_a: assert property (disable iff (1'b0)
    reset |=> !spi_sdo_oe && control_reg == 8'h00 &&
    configuration_reg == 8'h00) else $error("not quiet after reset");
  // Released pin shows no stale data
  sdo_off_a: assert property (!spi_sdo_oe |-> !spi_sdo)
    else $error("sdo high while released");
  // Select fall turns the driver on within the sync window
  oe_start_a: assert property ($fell(spi_csn_n) |-> ##[1:5] spi_sdo_oe)
    else $error("driver late after select");
  oe_held_a: assert property (!spi_csn_n [*6] |-> spi_sdo_oe)
    else $error("driver dropped in frame");
  oe_release_a: assert property (spi_csn_n [*6] |-> !spi_sdo_oe)
    else $error("driver on while deselected");
  oe_cause_a: assert property (
    $rose(spi_sdo_oe) |-> !$past(spi_csn_n, 2) && !spi_csn_n)
    else $error("driver on without select");
  // Output moves only after a clock fall, so high clock means stable
  sdo_stable_a: assert property (
    spi_sck && $past(spi_sck) && $past(spi_sdo_oe) |-> $stable(spi_sdo))
    else $error("sdo moved while clock high");
  // Settings commit only after select rises
  commit_hold_a: assert property (
    !spi_csn_n [*8] |=> $stable(control_reg) && $stable(configuration_reg))
    else $error("settings changed in frame");
  undervolt_flag_a: assert property (
    $rose(spi_sdo_oe) && supply_undervoltage &&
    $past(supply_undervoltage, 6) |-> spi_sdo)
    else $error("error flag missing");
endmodule : sfsp_top_chk
bind sfsp_top sfsp_top_chk #(.CH(CH)) chk (
  .sys_clk(sys_clk), .reset(reset), .spi_sck(spi_sck),
  .spi_csn_n(spi_csn_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
  .supply_undervoltage(supply_undervoltage), .control_reg(control_reg),
  .configuration_reg(configuration_reg));
`default_nettype wire

//--- sim/test_spi_frame_status_protocol.sv
// Purpose: Self-checking bench for the serial frame engine
// Assumes: Info bytes at the engine's default values
// Notes: Driver queues expected words, a watcher compares them
`timescale 1ns/1ps
`default_nettype none
module test_spi_frame_status_protocol;
  import sfsp_pkg::*;
  typedef struct packed {logic [15:0] exp; logic [15:0] mask;} sfsp_note_s;
  logic sys_clk, reset, spi_sck, spi_csn_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic case_ot, sel_to, uv, pwm_low, failsafe, soft_rst, rx_stb;
  logic [3:0] flt [5];
  logic [7:0] readback, gen_stat, control_reg, configuration_reg;
  logic [7:0] mem [64];
  logic [15:0] rx_word;
  wire sdo_line;
  int n_errors, num_checks, seed;
  sfsp_note_s notes[$];
  logic [5:0] addr_tab [8] = '{6'h01, 6'h09, 6'h10, 6'h13, 6'h18, 6'h1b,
                               6'h3e, 6'h3f};
  logic [5:0] info_a [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3e, 6'h05};
  logic [7:0] info_v [6] = '{8'h5a, 8'h01, 8'h11, 8'h22, 8'h01, 8'h00};
  logic [7:0] sbit [5] = '{8'h10, 8'h04, 8'h02, 8'h10, 8'h10};
  // Released pin floats
  assign sdo_line = spi_sdo_oe ? spi_sdo : 1'bz;
  sfsp_top #(.CH(4)) dut (
    .sys_clk(sys_clk), .reset(reset), .spi_sck(spi_sck),
    .spi_csn_n(spi_csn_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .thermal_shutdown_fault(flt[0]),
    .open_load_on_fault(flt[1]), .open_load_off_fault(flt[2]),
    .power_limit_fault(flt[3]), .overload_fault(flt[4]),
    .case_overtemp(case_ot), .select_monitor_timeout(sel_to),
    .supply_undervoltage(uv), .pwm_clock_low(pwm_low),
    .failsafe_mode(failsafe), .soft_reset(soft_rst),
    .channel_readback(readback), .general_status(gen_stat),
    .control_reg(control_reg), .configuration_reg(configuration_reg));
  sfsp_master_model master (
    .spi_sck(spi_sck), .spi_csn_n(spi_csn_n), .spi_sdi(spi_sdi),
    .spi_sdo(sdo_line), .rx_word(rx_word), .rx_stb(rx_stb));
  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // Queue the expectation, then run the frame
  task automatic frame(input logic [1:0] op, input logic [5:0] a,
                       input logic [7:0] d, input int p,
                       input logic [15:0] e, input logic [15:0] m);
    notes.push_back('{e, m});
    master.xfer({op, a, d}, p);
  endtask : frame
  task automatic pulse(input int k, input int ch);
    @(negedge sys_clk);
    flt[k][ch] = 1'b1;
    @(negedge sys_clk);
    flt[k][ch] = 1'b0;
  endtask : pulse
  // Watcher: oldest note against each received word
  initial begin : watch
    sfsp_note_s n;
    forever begin
      @(posedge rx_stb);
      n = notes.pop_front();
      if (n.mask != 16'h0000) begin
        num_checks++;
        if ((rx_word & n.mask) !== (n.exp & n.mask)) begin
          $display("FAIL %0t got %h exp %h", $time, rx_word, n.exp);
          n_errors++;
        end
        if (n.mask[8] && (rx_word[15:8] === 8'hff ||
            rx_word[15:8] === 8'h00)) begin
          $display("FAIL %0t status byte shows link failure", $time);
          n_errors++;
        end
      end
    end
  end
  // Hang guard
  initial begin
    #400us;
    $display("FAIL %0t timeout", $time);
    n_errors++;
    wrap_up();
  end
  initial begin : main
    logic [7:0] v;
    logic [5:0] a;
    int k;
    seed = 32'hcee111f8;
    reset = 1'b1;
    {case_ot, sel_to, uv, pwm_low, failsafe, soft_rst} = 6'h00;
    for (k = 0; k < 5; k++) flt[k] = 4'h0;
    for (k = 0; k < 64; k++) mem[k] = 8'h00;
    readback = $random(seed);
    gen_stat = $random(seed);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    frame(OP_READ, A_CTRL, 8'h00, 0, 16'h8000, 16'h8000);
    frame(OP_READ, A_CTRL, 8'h00, 16, 16'h8000, 16'hffff);
    frame(OP_WRITE, A_CTRL, 8'ha5, 16, 16'h2000, 16'hffff);
    frame(OP_READ, A_CTRL, 8'h3c, 16, 16'h20a5, 16'hffff);
    mem[0] = 8'ha5;
    for (k = 0; k < 12; k++) begin
      a = addr_tab[{$random(seed)} % 8];
      v = $random(seed);
      frame(OP_WRITE, a, v, 16, {8'h20, mem[a]}, 16'hffff);
      mem[a] = v;
      frame(OP_READ, a, ~v, 16, {8'h20, v}, 16'hffff);
    end
    num_checks++;
    if (control_reg !== 8'ha5 || configuration_reg !== mem[63]) begin
      $display("FAIL %0t stored settings wrong", $time);
      n_errors++;
    end
    frame(OP_WRITE, A_READBACK, 8'hff, 16, {8'h20, readback}, 16'hffff);
    frame(OP_READ, A_GENERAL, 8'h00, 16, {8'h20, gen_stat}, 16'hffff);
    frame(OP_WRITE, 6'h0a, 8'h5a, 16, 16'h2000, 16'hffff);
    frame(OP_READ, 6'h0a, 8'h00, 16, 16'h2000, 16'hffff);
    frame(OP_RDCLR, 6'h35, 8'h00, 16, 16'h2000, 16'hffff);
    for (k = 0; k < 6; k++) begin
      v = $random(seed);
      frame(OP_INFO, info_a[k], v, 16, {8'h20, info_v[k]}, 16'hffff);
    end
    // Each fault kind: raise, read and clear, confirm cleared
    for (k = 0; k < 5; k++) begin
      pulse(k, k % 4);
      frame(OP_RDCLR, 6'h30 + 6'(k), 8'hff, 16,
            {8'ha0 | sbit[k], 8'(1 << (k % 4))}, 16'hffff);
      frame(OP_READ, 6'h30 + 6'(k), 8'h00, 16, 16'h2000, 16'hffff);
    end
    // Event in mid-frame stays out of that frame
    fork
      frame(OP_READ, A_PLIM, 8'h00, 16, 16'h2000, 16'hffff);
      begin
        #700;
        pulse(3, 2);
      end
    join
    for (k = 0; k < 5; k++) pulse(k, 1);
    frame(OP_RDCLR, A_CONFIG, 8'h00, 16, {8'hb6, mem[63]}, 16'hffff);
    frame(OP_READ, A_PLIM, 8'h00, 16, 16'h2000, 16'hffff);
    // Short and long frames are refused and flagged once
    for (k = 15; k <= 17; k += 2) begin
      frame(OP_WRITE, A_CTRL, 8'h3c, k, 16'h0000, 16'h0000);
      frame(OP_READ, A_CTRL, 8'h00, 16, 16'hc0a5, 16'hffff);
      frame(OP_READ, A_CTRL, 8'h00, 16, 16'h20a5, 16'hffff);
    end
    // Clock high at select fall is a wrong mode
    frame(OP_WRITE, A_CTRL, 8'h3c, 116, 16'h0000, 16'h0000);
    frame(OP_READ, A_CTRL, 8'h00, 16, 16'hc0a5, 16'hffff);
    @(negedge sys_clk) soft_rst = 1'b1;
    @(negedge sys_clk) soft_rst = 1'b0;
    frame(OP_READ, A_CTRL, 8'h00, 16, 16'h80a5, 16'hffff);
    @(negedge sys_clk) {case_ot, failsafe} = 2'b11;
    frame(OP_READ, A_CTRL, 8'h00, 16, 16'h29a5, 16'hffff);
    for (k = 0; k < 3; k++) begin
      @(negedge sys_clk) {pwm_low, uv, sel_to} = 3'(1 << k);
      repeat (8) @(negedge sys_clk);
      frame(OP_READ, A_CTRL, 8'h00, 16, 16'ha9a5, 16'hffff);
    end
    @(negedge sys_clk) {pwm_low, uv, sel_to, case_ot, failsafe} = 5'h00;
    frame(OP_READ, A_CTRL, 8'h00, 16, 16'h20a5, 16'hffff);
    for (k = 0; k < 50 && notes.size() > 0; k++) @(posedge sys_clk);
    if (notes.size() != 0) begin
      $display("FAIL %0t results missing", $time);
      n_errors++;
    end
    wrap_up();
  end
endmodule : test_spi_frame_status_protocol
`default_nettype wire
